// *** hdl/pcs_consts.svh ***
// Overview of operation
// - control bit 7 set: col output follows tx_en with minimal delay; clear: normal.
// - control bit 6 is the forced speed code msb, paired with the lsb from the forced_speed_low_bit input.
// - control bits 5:0 are reserved, read-only, written zero, ignored on read.
// - status register is read-only; writes to it change nothing at all.
// - status bits 15:9 report support of the seven listed 100/10 modes.
// - status bit 8 says extended gigabit status exists in register 15.
// - status bit 6 says frames without preamble are accepted.
// - status bit 5 reads 0 while autoneg runs, 1 once it completed.
// - status bit 4 latches high when a remote fault is detected.
// - status bit 3 says the device can auto-negotiate.
// - two latching status kinds exist: latch-high and latch-low.
// - status bit 2 is the latch-low link indicator, 1 when link up.
// - status bit 1 latches high when jabber is detected.
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// register addresses on the management frame
`define PCS_ADDR_CTRL     5'h00
`define PCS_ADDR_STAT     5'h01

// management frame fields
`define PCS_OP_WRITE      2'h1
`define PCS_OP_READ       2'h2
`define PCS_HDR_LAST      4'hb
`define PCS_DATA_LAST     4'hf

// control register fields and reset value
`define PCS_CTRL_RST         16'h1040
`define PCS_CTRL_COL_BIT     7
`define PCS_CTRL_SPD_HI_BIT  6
`define PCS_CTRL_SPD_LO_BIT  13

// status register fields and reset value
`define PCS_STAT_RST         16'h7949
`define PCS_STAT_AN_DONE_BIT 5
`define PCS_STAT_FAULT_BIT   4
`define PCS_STAT_LINK_BIT    2
`define PCS_STAT_JAB_BIT     1
`define PCS_STAT_DYN_MASK 16'h0036

`endif

// *** hdl/pcs_pkg.sv ***
package pcs_pkg;

   // management frame engine, gray along idle-start-header-turn-data
   typedef enum logic [2:0] {
      PCS_IDLE  = 3'h0,
      PCS_START = 3'h1,
      PCS_HDR   = 3'h3,
      PCS_TURN  = 3'h2,
      PCS_DATA  = 3'h6
   } pcs_state_t;

   // writable low byte of the basic control register
   typedef struct packed {
      logic col_test;
      logic forced_speed_high_bit;
   } pcs_ctrl_t;

   // decoded frame header
   typedef struct packed {
      logic [1:0] op;
      logic [4:0] phy;
      logic [4:0] regad;
   } pcs_hdr_t;

endpackage

// *** hdl/pcs_latch.sv ***
`timescale 1ns/1ps
// one latching status bit; event level is 1 for latch-high, 0 for latch-low
module pcs_latch #(
   parameter logic LATCH_HIGH = 1'b1
) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic live,
   input  wire logic rd_clr,
   output wire logic value
);
   logic seen_reg;
   logic seen_next;
   wire  event_now = (live == LATCH_HIGH);

   // set wins over the read clear, so an event during a read is not lost
   assign seen_next = event_now ? 1'b1 : (rd_clr ? 1'b0 : seen_reg);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         seen_reg <= 1'b0;
      end else begin
         seen_reg <= seen_next;
      end
   end

   // held event value until read, live value afterwards
   assign value = seen_reg ? LATCH_HIGH : live;

   held_event_a: assert property (@(posedge mclk) disable iff (!nrst)
      (event_now && !rd_clr) |=> (value == LATCH_HIGH))
      else $error("latched status bit lost its event");
endmodule // pcs_latch

// *** hdl/pcs_regs.sv ***
`timescale 1ns/1ps
`include "pcs_consts.svh"
// basic control low byte and basic status, reached over the management pins
module pcs_regs (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe,
   input  wire logic [4:0] phy_addr,
   input  wire logic       tx_en,
   input  wire logic       col_in,
   output logic            col_out,
   input  wire logic       forced_speed_low_bit,
   output logic [1:0]      forced_speed,
   input  wire logic       autoneg_done,
   input  wire logic       remote_fault,
   input  wire logic       link_up,
   input  wire logic       jabber
);
   pcs_pkg::pcs_state_t state_reg;
   pcs_pkg::pcs_state_t state_next;
   pcs_pkg::pcs_ctrl_t  ctrl_reg;
   pcs_pkg::pcs_ctrl_t  ctrl_next;
   pcs_pkg::pcs_hdr_t   hdr_next;
   logic [11:0]         hdr_reg;
   logic [11:0]         hdr_shift;
   logic [3:0]          cnt_reg;
   logic [3:0]          cnt_next;
   logic [15:0]         sh_reg;
   logic [15:0]         sh_next;
   logic                is_rd_reg;
   logic                is_rd_next;
   logic                is_wr_reg;
   logic                is_wr_next;
   logic                mdc_prev_reg;
   logic                out_next;
   logic                oe_next;
   logic                stat_rd;
   logic                fault_val;
   logic                link_val;
   logic                jab_val;

   // reset image of the control word; the stored bits are picked from it
   localparam logic [15:0] CTRL_RST_WORD = `PCS_CTRL_RST;

   // edge of the management clock, sampled on mclk
   wire mdc_rise = mdc & ~mdc_prev_reg;

   // header decode as it completes on the last header bit
   assign hdr_shift = {hdr_reg[10:0], mdio_in};
   assign hdr_next  = pcs_pkg::pcs_hdr_t'(hdr_shift);
   wire hdr_done  = mdc_rise && (state_reg == pcs_pkg::PCS_HDR) && (cnt_reg == `PCS_HDR_LAST);
   wire addr_hit  = (hdr_next.phy == phy_addr);
   wire load_rd   = hdr_done && addr_hit && (hdr_next.op == `PCS_OP_READ);
   wire load_wr   = hdr_done && addr_hit && (hdr_next.op == `PCS_OP_WRITE);
   wire sel_ctrl  = (hdr_next.regad == `PCS_ADDR_CTRL);
   wire sel_stat  = (hdr_next.regad == `PCS_ADDR_STAT);

   // write completes on the last data bit
   wire [15:0] wr_word = {sh_reg[14:0], mdio_in};
   wire data_end  = mdc_rise && (state_reg == pcs_pkg::PCS_DATA) && (cnt_reg == `PCS_DATA_LAST);
   wire wr_commit = data_end && is_wr_reg;
   wire wr_ctrl   = wr_commit && (hdr_reg[4:0] == `PCS_ADDR_CTRL);

   // reading status clears the latches, at the moment it is snapshotted
   assign stat_rd = load_rd && sel_stat;

   // latch-high remote fault and jabber, latch-low link
   pcs_latch #(.LATCH_HIGH(1'b1)) u_fault_latch (
      .mclk   (mclk),
      .nrst   (nrst),
      .live   (remote_fault),
      .rd_clr (stat_rd),
      .value  (fault_val)
   );
   pcs_latch #(.LATCH_HIGH(1'b0)) u_link_latch (
      .mclk   (mclk),
      .nrst   (nrst),
      .live   (link_up),
      .rd_clr (stat_rd),
      .value  (link_val)
   );
   pcs_latch #(.LATCH_HIGH(1'b1)) u_jab_latch (
      .mclk   (mclk),
      .nrst   (nrst),
      .live   (jabber),
      .rd_clr (stat_rd),
      .value  (jab_val)
   );

   // status word: fixed abilities from the reset image, autoneg bit live, fault, link and jabber from the latches
   function automatic logic [15:0] stat_word(input logic an, input logic fault,
                                              input logic link, input logic jab);
      logic [15:0] w;
      w = `PCS_STAT_RST & ~`PCS_STAT_DYN_MASK;
      w[`PCS_STAT_AN_DONE_BIT] = an;
      w[`PCS_STAT_FAULT_BIT]   = fault;
      w[`PCS_STAT_LINK_BIT]    = link;
      w[`PCS_STAT_JAB_BIT]     = jab;
      return w;
   endfunction

   // control word: reserved low bits always read zero
   function automatic logic [15:0] ctrl_word(input pcs_pkg::pcs_ctrl_t c, input logic spd_lo);
      logic [15:0] w;
      w = 16'h0000;
      w[`PCS_CTRL_COL_BIT]    = c.col_test;
      w[`PCS_CTRL_SPD_HI_BIT] = c.forced_speed_high_bit;
      w[`PCS_CTRL_SPD_LO_BIT] = spd_lo;
      return w;
   endfunction

   wire [15:0] rd_word = sel_ctrl ? ctrl_word(ctrl_reg, forced_speed_low_bit) :
                         sel_stat ? stat_word(autoneg_done, fault_val, link_val, jab_val) :
                         16'h0000;

   // only the control register takes writes; status writes fall through
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next.col_test              = wr_word[`PCS_CTRL_COL_BIT];
         ctrl_next.forced_speed_high_bit = wr_word[`PCS_CTRL_SPD_HI_BIT];
      end
   end

   // frame engine; preamble is optional since suppression is advertised
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      is_rd_next = is_rd_reg;
      is_wr_next = is_wr_reg;
      out_next   = mdio_out;
      oe_next    = mdio_oe;
      if (mdc_rise) begin
         case (state_reg)
            pcs_pkg::PCS_IDLE: begin
               if (!mdio_in) begin
                  state_next = pcs_pkg::PCS_START;
               end
            end
            pcs_pkg::PCS_START: begin
               state_next = mdio_in ? pcs_pkg::PCS_HDR : pcs_pkg::PCS_IDLE;
               cnt_next   = 4'h0;
            end
            pcs_pkg::PCS_HDR: begin
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg == `PCS_HDR_LAST) begin
                  state_next = pcs_pkg::PCS_TURN;
                  cnt_next   = 4'h0;
                  is_rd_next = load_rd;
                  is_wr_next = load_wr;
                  sh_next    = rd_word;
               end
            end
            pcs_pkg::PCS_TURN: begin
               cnt_next = cnt_reg + 4'h1;
               if (cnt_reg == 4'h0) begin
                  oe_next  = is_rd_reg; // second turnaround bit driven low
                  out_next = 1'b0;
               end else begin
                  state_next = pcs_pkg::PCS_DATA;
                  cnt_next   = 4'h0;
                  out_next   = is_rd_reg & sh_reg[15];
                  sh_next    = {sh_reg[14:0], 1'b0};
               end
            end
            pcs_pkg::PCS_DATA: begin
               cnt_next = cnt_reg + 4'h1;
               out_next = is_rd_reg & sh_reg[15];
               sh_next  = {sh_reg[14:0], mdio_in};
               if (cnt_reg == `PCS_DATA_LAST) begin
                  state_next = pcs_pkg::PCS_IDLE;
                  cnt_next   = 4'h0;
                  oe_next    = 1'b0;
                  out_next   = 1'b0;
                  is_rd_next = 1'b0;
                  is_wr_next = 1'b0;
               end
            end
            default: begin
               state_next = pcs_pkg::PCS_IDLE;
               oe_next    = 1'b0;
               out_next   = 1'b0;
            end
         endcase
      end
   end

   // frame engine state and pin drivers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_reg    <= pcs_pkg::PCS_IDLE;
         cnt_reg      <= 4'h0;
         sh_reg       <= 16'h0000;
         hdr_reg      <= 12'h000;
         is_rd_reg    <= 1'b0;
         is_wr_reg    <= 1'b0;
         mdc_prev_reg <= 1'b0;
         mdio_out     <= 1'b0;
         mdio_oe      <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         sh_reg       <= sh_next;
         hdr_reg      <= (mdc_rise && state_reg == pcs_pkg::PCS_HDR) ? hdr_shift : hdr_reg;
         is_rd_reg    <= is_rd_next;
         is_wr_reg    <= is_wr_next;
         mdc_prev_reg <= mdc;
         mdio_out     <= out_next;
         mdio_oe      <= oe_next;
      end
   end

   // control bits and the outputs they steer; one mclk of collision latency
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg     <= pcs_pkg::pcs_ctrl_t'({CTRL_RST_WORD[`PCS_CTRL_COL_BIT],
                                               CTRL_RST_WORD[`PCS_CTRL_SPD_HI_BIT]});
         col_out      <= 1'b0;
         forced_speed <= 2'h0;
      end else begin
         ctrl_reg     <= ctrl_next;
         col_out      <= ctrl_reg.col_test ? tx_en : col_in;
         forced_speed <= {ctrl_reg.forced_speed_high_bit, forced_speed_low_bit};
      end
   end

   // checks on the logic above
   col_loop_a: assert property (@(posedge mclk) disable iff (!nrst)
      ctrl_reg.col_test |=> (col_out == $past(tx_en)))
      else $error("collision test does not follow tx_en");

   col_normal_a: assert property (@(posedge mclk) disable iff (!nrst)
      !ctrl_reg.col_test |=> (col_out == $past(col_in)))
      else $error("normal collision path broken");

   speed_pair_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_ctrl ##1 1'b1 |=> (forced_speed[1] == $past(wr_word[`PCS_CTRL_SPD_HI_BIT], 2)))
      else $error("forced speed msb not taken from control write");

   ctrl_resv_a: assert property (@(posedge mclk) disable iff (!nrst)
      (load_rd && sel_ctrl) |=> (sh_reg[5:0] == 6'h00))
      else $error("reserved control bits read nonzero");

   stat_write_a: assert property (@(posedge mclk) disable iff (!nrst)
      (wr_commit && hdr_reg[4:0] == `PCS_ADDR_STAT) |=> $stable(ctrl_reg))
      else $error("status write changed device state");

   stat_caps_a: assert property (@(posedge mclk) disable iff (!nrst)
      stat_rd |=> ((sh_reg & ~`PCS_STAT_DYN_MASK) == `PCS_STAT_RST))
      else $error("status ability bits wrong");

   an_done_a: assert property (@(posedge mclk) disable iff (!nrst)
      stat_rd |=> (sh_reg[`PCS_STAT_AN_DONE_BIT] == $past(autoneg_done)))
      else $error("autoneg complete bit wrong");

   fault_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      (remote_fault && !stat_rd) ##1 (!stat_rd && !remote_fault) |-> fault_val)
      else $error("remote fault not held until read");

   link_low_a: assert property (@(posedge mclk) disable iff (!nrst)
      (!link_up && !stat_rd) ##1 (!stat_rd) |-> !link_val)
      else $error("link drop not held until read");

   jab_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      (jabber && !stat_rd) |=> (stat_rd or jab_val))
      else $error("jabber not held until read");

   read_turn_a: assert property (@(posedge mclk) disable iff (!nrst)
      load_rd |=> !mdio_oe)
      else $error("device drove the first turnaround bit");

   // after a read with no new event the latches give the live level again
   fault_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
      (stat_rd && !remote_fault) |=> (fault_val == remote_fault))
      else $error("remote fault stuck after read");

   link_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
      (stat_rd && link_up) |=> (link_val == link_up))
      else $error("link status stuck after read");

   jab_follow_a: assert property (@(posedge mclk) disable iff (!nrst)
      (stat_rd && !jabber) |=> (jab_val == jabber))
      else $error("jabber stuck after read");

   // only a finished control write may move the stored control bits
   ctrl_only_a: assert property (@(posedge mclk) disable iff (!nrst)
      !wr_ctrl |=> $stable(ctrl_reg))
      else $error("control bits moved without a control write");

   // the speed lsb passes with the same one mclk latency as the msb
   speed_low_a: assert property (@(posedge mclk) disable iff (!nrst)
      1'b1 |=> (forced_speed[0] == $past(forced_speed_low_bit)))
      else $error("forced speed lsb not taken from its input");

   rd_frame_c:  cover property (@(posedge mclk) disable iff (!nrst) stat_rd);
   wr_frame_c:  cover property (@(posedge mclk) disable iff (!nrst) wr_ctrl);
   col_test_c:  cover property (@(posedge mclk) disable iff (!nrst) ctrl_reg.col_test && tx_en);
   fault_latch_c: cover property (@(posedge mclk) disable iff (!nrst)
      stat_rd && fault_val && !remote_fault);
   stat_wr_c:   cover property (@(posedge mclk) disable iff (!nrst)
      wr_commit && (hdr_reg[4:0] == `PCS_ADDR_STAT));
endmodule // pcs_regs

// *** bench/pcs_sta.sv ***
`timescale 1ns/1ps
// station management model: drives mdc and its mdio side, samples the shared line
module pcs_sta (
   input  wire logic mclk,
   input  wire logic mdio_line,
   output logic      mdc,
   output logic      sta_out,
   output logic      sta_oe
);
   localparam int HALF = 4; // mdc half period in mclk, kept above the 2 mclk minimum

   // idle: clock stands low, line released to the pull-up
   initial begin
      mdc = 1'b0;
      sta_out = 1'b1;
      sta_oe = 1'b0;
   end

   // one mdc period: set data while low, sample just before the rise
   task automatic bit_cycle(input logic drive, input logic val, output logic seen);
      @(negedge mclk);
      sta_oe = drive;
      sta_out = val;
      repeat (HALF) @(negedge mclk);
      seen = mdio_line;
      mdc = 1'b1;
      repeat (HALF) @(negedge mclk);
      mdc = 1'b0;
   endtask

   // whole frame without preamble; reads release the line from the turnaround on
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                        input logic [15:0] wdata, output logic [15:0] rdata,
                        output logic ta2);
      logic [13:0] hdr;
      logic        wr;
      logic        seen;
      hdr = {2'b01, op, phy, regad};
      wr = (op == 2'h1);
      for (int i = 0; i < 32; i++) begin
         if (i < 14) bit_cycle(1'b1, hdr[13 - i], seen);
         else if (i < 16) bit_cycle(wr, i == 14, seen);
         else bit_cycle(wr, wdata[31 - i], seen);
         if (i == 15) ta2 = seen;
         if (i >= 16) rdata[31 - i] = seen;
      end
      sta_oe = 1'b0;
   endtask
endmodule // pcs_sta

// *** bench/tb_phy_ctrl_status_regs.sv ***
`timescale 1ns/1ps
`include "pcs_consts.svh"
module tb_phy_ctrl_status_regs;
   localparam logic [4:0] MY = 5'h0a; // management address of the device
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        mdc;
   logic        mdio_out;
   logic        mdio_oe;
   logic        sta_out;
   logic        sta_oe;
   logic        tx_en = 1'b0;
   logic        col_in = 1'b1;
   logic        col_out;
   logic        low_bit = 1'b1;
   logic [1:0]  forced_speed;
   logic        an = 1'b0;
   logic        fault_in = 1'b0;
   logic        link_in = 1'b1;
   logic        jab_in = 1'b0;
   logic [15:0] rdat;
   logic        ta2;
   int          err_count = 0;
   int          num_checks = 0;
   // shared line: pull-up wins when nobody drives
   wire         mdio_line = sta_oe ? sta_out : (mdio_oe ? mdio_out : 1'b1);

   pcs_regs pcs_regs_i (
      .mclk(mclk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .phy_addr(MY), .tx_en(tx_en), .col_in(col_in),
      .col_out(col_out), .forced_speed_low_bit(low_bit), .forced_speed(forced_speed),
      .autoneg_done(an), .remote_fault(fault_in), .link_up(link_in), .jabber(jab_in)
   );
   pcs_sta pcs_sta_i (
      .mclk(mclk), .mdio_line(mdio_line), .mdc(mdc), .sta_out(sta_out), .sta_oe(sta_oe)
   );

   // 40 mhz
   always #12.5 mclk = ~mclk;

   task automatic test_done();
      if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                       input logic [15:0] wdata);
      pcs_sta_i.frame(op, phy, regad, wdata, rdat, ta2);
   endtask

   // status read and compare; bit 7 is masked since its value carries no meaning
   task automatic stat_is(input logic a, input logic r, input logic l, input logic j);
      xfer(`PCS_OP_READ, MY, `PCS_ADDR_STAT, 16'h0000);
      check("status", rdat & 16'hff7f, `PCS_STAT_RST | {10'h0, a, r, 1'b0, l, j, 1'b0});
   endtask

   // watchdog: a hang is a mismatch
   initial begin
      repeat (100000) @(posedge mclk);
      err_count++;
      test_done();
   end

   // main sequence
   initial begin
      repeat (6) @(posedge mclk);
      check("oe in reset", {15'h0, mdio_oe}, 16'h0000);
      check("speed in reset", {14'h0, forced_speed}, 16'h0000);
      @(negedge mclk);
      nrst = 1'b1;
      repeat (2) @(negedge mclk);
      check("col after reset", {15'h0, col_out}, 16'h0001);
      check("speed after reset", {14'h0, forced_speed}, 16'h0003);
      xfer(`PCS_OP_READ, MY, `PCS_ADDR_CTRL, 16'h0000);
      check("ctrl reset", rdat, 16'h2040);
      stat_is(1'b0, 1'b0, 1'b1, 1'b0);
      check("turnaround", {15'h0, ta2}, 16'h0000);
      // one-cycle fault, jabber and link events with autoneg left complete, then those three back to quiet
      @(negedge mclk);
      fault_in = 1'b1;
      jab_in = 1'b1;
      link_in = 1'b0;
      an = 1'b1;
      @(negedge mclk);
      fault_in = 1'b0;
      jab_in = 1'b0;
      link_in = 1'b1;
      stat_is(1'b1, 1'b1, 1'b0, 1'b1);
      stat_is(1'b1, 1'b0, 1'b1, 1'b0);
      // the station keeps the reserved bits zero on every control write
      xfer(`PCS_OP_WRITE, MY, `PCS_ADDR_CTRL, 16'h00c0);
      xfer(`PCS_OP_READ, MY, `PCS_ADDR_CTRL, 16'h0000);
      check("ctrl test on", rdat, 16'h20c0);
      check("speed msb on", {14'h0, forced_speed}, 16'h0003);
      @(negedge mclk);
      col_in = 1'b0;
      tx_en = 1'b1;
      repeat (2) @(negedge mclk);
      check("col loop high", {15'h0, col_out}, 16'h0001);
      tx_en = 1'b0;
      col_in = 1'b1;
      repeat (2) @(negedge mclk);
      check("col loop low", {15'h0, col_out}, 16'h0000);
      xfer(`PCS_OP_WRITE, MY, `PCS_ADDR_CTRL, 16'h0000);
      repeat (2) @(negedge mclk);
      check("col normal", {15'h0, col_out}, 16'h0001);
      check("speed msb off", {14'h0, forced_speed}, 16'h0001);
      low_bit = 1'b0;
      repeat (2) @(negedge mclk);
      check("speed low off", {14'h0, forced_speed}, 16'h0000);
      // status writes change nothing
      xfer(`PCS_OP_WRITE, MY, `PCS_ADDR_STAT, 16'hffff);
      stat_is(1'b1, 1'b0, 1'b1, 1'b0);
      xfer(`PCS_OP_READ, MY, `PCS_ADDR_CTRL, 16'h0000);
      check("ctrl after stat write", rdat, 16'h0000);
      // refused frames leave the line to the pull-up
      for (int k = 0; k < 3; k++) begin
         xfer(k == 2 ? `PCS_OP_READ : 2'(3 * k), k == 2 ? 5'h01 : MY, `PCS_ADDR_CTRL,
              16'h0000);
         check("refused read", rdat, 16'hffff);
      end
      xfer(`PCS_OP_WRITE, 5'h01, `PCS_ADDR_CTRL, 16'h00c0);
      xfer(`PCS_OP_READ, MY, `PCS_ADDR_CTRL, 16'h0000);
      check("ctrl after foreign write", rdat, 16'h0000);
      xfer(`PCS_OP_READ, MY, 5'h05, 16'h0000);
      check("unmapped read", rdat, 16'h0000);
      test_done();
   end
endmodule // tb_phy_ctrl_status_regs
